// ### dv/sab_fet_model.sv
// Rectifier switch sensing: periodic off phase, then conduction phase.
// Assumes lengths change only between clk edges; gate does not shift timing.
`timescale 1ns/1ps
`default_nettype none
module sab_fet_model (
  input wire logic clk,
  input wire logic [7:0] on_len,
  input wire logic [7:0] off_len,
  output logic below_turn_on_threshold,
  output logic above_turn_off_threshold,
  output logic drain_above_source
);
  logic [8:0] ph = 9'h000;
  // Short on_len mimics a ring dip, short off_len a diode in blanking
  always @(posedge clk) begin
    ph <= (ph + 9'h001 >= {1'b0, off_len} + {1'b0, on_len}) ? 9'h000 : ph + 9'h001;
  end
  assign drain_above_source = ph < {1'b0, off_len};
  assign above_turn_off_threshold = drain_above_source;
  assign below_turn_on_threshold = !drain_above_source;
endmodule
`default_nettype wire

// ### dv/sab_timing_props.sv
// Checker of gate sequencing at the timing core ports.
// Assumes one clk; srst and uv_flag both act as reset of the core.
`timescale 1ns/1ps
`default_nettype none
module sab_timing_props
  import sab_pkg::*;
#(parameter bit SLOW_VARIANT = 1'b0) (
  input wire logic clk,
  input wire logic srst,
  input wire logic uv_flag,
  input wire logic below_turn_on_threshold,
  input wire logic above_turn_off_threshold,
  input wire logic drain_above_source,
  input wire logic gate_drive_out,
  input wire logic prop_drive_enable,
  input wire logic armed
);
  localparam int MIN_ON = SLOW_VARIANT ? int'(SAB_MIN_ON_SLOW_CYC) : int'(SAB_MIN_ON_FAST_CYC);
  logic [7:0] on_run, off_run, quiet, last_on;
  logic dirty;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || uv_flag);
  // ----------------------------------------
  // Run-length counters, saturating at 255
  // ----------------------------------------
  always_ff @(posedge clk) begin
    on_run <= (srst || uv_flag || !gate_drive_out) ? 8'h00 : on_run + {7'h00, on_run != 8'hFF};
    off_run <= (srst || uv_flag || gate_drive_out) ? 8'h00 : off_run + {7'h00, off_run != 8'hFF};
    quiet <= (srst || uv_flag || dirty || gate_drive_out || below_turn_on_threshold
      || !drain_above_source) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
    // Turn-on level while unarmed: a skipped cycle may delay the next arm
    if (srst || uv_flag || armed) begin
      dirty <= 1'b0;
    end else if (below_turn_on_threshold && !gate_drive_out) begin
      dirty <= 1'b1;
    end
    if (srst || uv_flag) begin
      last_on <= 8'h00;
    end else if (!gate_drive_out && on_run != 8'h00) begin
      last_on <= on_run;
    end
  end
  sequence s_turn_on;
    (armed && below_turn_on_threshold)[*3];
  endsequence
  sequence s_release;
    above_turn_off_threshold[*3] ##0 (on_run >= 8'h18);
  endsequence
  a_gate_needs_arm: assert property ($rose(gate_drive_out) |-> $past(armed))
    else $error("gate rose without arm");
  a_min_on_hold: assert property ($fell(gate_drive_out) |-> on_run >= MIN_ON)
    else $error("gate pulse shorter than minimum on-time");
  a_blank_floor: assert property ($rose(armed) |-> off_run >= SAB_FLOOR_CYC)
    else $error("arm came before blanking floor");
  a_blank_ceiling: assert property (quiet == 8'hA0 |-> armed)
    else $error("blanking exceeded its ceiling");
  a_diode_skip: assert property ($rose(armed) |-> !$past(below_turn_on_threshold, 4))
    else $error("armed after diode conduction in blanking");
  a_turn_on_follow: assert property (s_turn_on |-> ##[0:1] gate_drive_out)
    else $error("gate missed armed turn-on");
  a_turn_off_follow: assert property (s_release |-> ##[1:2] !gate_drive_out)
    else $error("gate missed turn-off");
  a_prop_half: assert property ($rose(prop_drive_enable) |-> on_run + 2 >= last_on / 2)
    else $error("proportional drive enabled too early");
  a_uv_off: assert property (@(posedge clk) disable iff (srst)
    uv_flag[*3] |=> !gate_drive_out && !armed)
    else $error("gate or arm active in undervoltage");
endmodule
bind sab_timing sab_timing_props #(.SLOW_VARIANT(SLOW_VARIANT)) u_props (.clk(clk), .srst(srst),
  .uv_flag(uv_flag), .below_turn_on_threshold(below_turn_on_threshold),
  .above_turn_off_threshold(above_turn_off_threshold), .drain_above_source(drain_above_source),
  .gate_drive_out(gate_drive_out), .prop_drive_enable(prop_drive_enable), .armed(armed));
`default_nettype wire

// ### dv/sr_adaptive_blanking_timing_bench.sv
// Self-checking bench of the timing core against the sensing model.
// Assumes the fast variant and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sr_adaptive_blanking_timing_bench;
  import sab_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic uv_flag = 1'b0;
  logic [7:0] on_len = 8'h20;
  logic [7:0] off_len = 8'h08;
  logic below, above, drain, gate, prop, armed;
  logic [31:0] seed = 32'hB7E8;
  int err_total = 0;
  int total_checks = 0;
  int rises = 0;
  int width = 0;
  int short_pulse = 0;
  int cyc = 0;
  always #12.5 clk = !clk;
  sab_fet_model i_fet (.clk(clk), .on_len(on_len), .off_len(off_len),
    .below_turn_on_threshold(below), .above_turn_off_threshold(above), .drain_above_source(drain));
  sab_timing #(.SLOW_VARIANT(1'b0)) i_dut (.clk(clk), .srst(srst), .uv_flag(uv_flag),
    .below_turn_on_threshold(below), .above_turn_off_threshold(above),
    .drain_above_source(drain), .gate_drive_out(gate), .prop_drive_enable(prop), .armed(armed));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Pulse monitor and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    width <= (gate === 1'b1) ? width + 1 : 0;
    if (gate === 1'b1 && width == 0) rises <= rises + 1;
    if (gate !== 1'b1 && width != 0 && width < SAB_MIN_ON_FAST_CYC) short_pulse <= short_pulse + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  // Six periods; the first may be skipped while blanking adapts
  task automatic run(input logic [7:0] off, input logic [7:0] on, input int lo, input int hi);
    int base;
    base = rises;
    off_len <= off;
    on_len <= on;
    repeat (6 * (int'(off) + int'(on)) + 20) @(posedge clk);
    check(int'(rises - base >= lo && rises - base <= hi), 1);
    check(short_pulse, 0);
    $display("test off %0d on %0d done", off, on);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    run(8'h08, 8'h1E, 0, 0);
    repeat (6) begin
      seed = xs(seed);
      run(8'h96 + {2'b00, seed[5:0]}, 8'h10 + {4'h0, seed[11:8]}, 3, 8);
    end
    run(8'hC8, 8'h04, 5, 8);
    run(8'hC8, 8'h1F, 5, 8);
    uv_flag <= 1'b1;
    // Two synchroniser stages, then the reset edge
    repeat (4) @(posedge clk);
    check(int'(gate === 1'b0 && armed === 1'b0 && prop === 1'b0), 1);
    $display("test undervoltage done");
    summarize();
  end
endmodule
`default_nettype wire

// ### src/sab_pkg.sv
// Package for the synchronous-rectifier adaptive blanking timer.
// Assumes a 40 MHz timing clock; all counts are in clock cycles.
package sab_pkg;
  localparam int unsigned SAB_CLK_MHZ = 40;
  localparam int unsigned SAB_CW = 12;
  // Times in nanoseconds as printed
  localparam int unsigned SAB_MIN_ON_FAST_NS = 360;
  localparam int unsigned SAB_MIN_ON_SLOW_NS = 540;
  localparam int unsigned SAB_FLOOR_NS = 400;
  localparam int unsigned SAB_CEIL_NS = 3680;
  // Least times round up, longest rounds down
  localparam int unsigned SAB_MIN_ON_FAST_CYC = (SAB_MIN_ON_FAST_NS * SAB_CLK_MHZ + 999) / 1000;
  localparam int unsigned SAB_MIN_ON_SLOW_CYC = (SAB_MIN_ON_SLOW_NS * SAB_CLK_MHZ + 999) / 1000;
  localparam int unsigned SAB_FLOOR_CYC = (SAB_FLOOR_NS * SAB_CLK_MHZ + 999) / 1000;
  localparam int unsigned SAB_CEIL_CYC = (SAB_CEIL_NS * SAB_CLK_MHZ) / 1000;
  // Scale factors in tenths
  localparam int unsigned SAB_OFF_SCALE_X10 = 7;
  localparam int unsigned SAB_RING_SCALE_X10 = 22;
  localparam logic [SAB_CW-1:0] SAB_CNT_MAX = 12'hFFF;

  typedef enum logic [3:0] {
    SAB_OFF_WAIT = 4'h1,
    SAB_BLANK = 4'h2,
    SAB_ARMED = 4'h4,
    SAB_ON = 4'h8
  } sab_state_t;
endpackage

// ### src/sab_sync.sv
// Two-flop synchroniser for one comparator level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sab_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sab_sync_t;
  sab_sync_t r;
  sab_sync_t next_r;
  always_comb begin
    next_r.meta = async_in;
    next_r.stable = r.meta;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign sync_out = r.stable;
endmodule
`default_nettype wire

// ### src/sab_timing.sv
// Timing and sequencing core of a synchronous-rectifier controller.
// Assumes comparator outputs are asynchronous; undervoltage flag acts as reset.
//
// Summary of operation
// - Proportional drive off during first half-conduction.
// - Hold gate on for minimum on-time.
// - Blanking is max of floor, clamp, scaled off.
// - Off term is seventy percent previous off.
// - Short conduction is false; record ring period.
// - Next cycle clamp becomes 2.2 ring periods.
// - Long diode conduction in blanking resets clamp.
// - Blanking ending after diode conduction skips turn-on.
// - Blanking saturates at 3.68 us.
// - Turn-on only when armed after blanking.
// - Blanking starts after drain exceeds source 500mV.
// - Undervoltage disables control, gate held off.
// - Gate follows turn-on and turn-off thresholds.
`timescale 1ns/1ps
`default_nettype none
module sab_timing
  import sab_pkg::*;
#(
  parameter bit SLOW_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic uv_flag,
  input wire logic below_turn_on_threshold,
  input wire logic above_turn_off_threshold,
  input wire logic drain_above_source,
  output logic gate_drive_out,
  output logic prop_drive_enable,
  output logic armed
);
  localparam logic [SAB_CW-1:0] MIN_ON = SLOW_VARIANT ? SAB_CW'(SAB_MIN_ON_SLOW_CYC)
                                                       : SAB_CW'(SAB_MIN_ON_FAST_CYC);
  localparam logic [SAB_CW-1:0] FLOOR = SAB_CW'(SAB_FLOOR_CYC);
  localparam logic [SAB_CW-1:0] CEIL = SAB_CW'(SAB_CEIL_CYC);

  typedef struct packed {
    sab_state_t st;
    logic [SAB_CW-1:0] on_cnt;
    logic [SAB_CW-1:0] off_cnt;
    logic [SAB_CW-1:0] blank_cnt;
    logic [SAB_CW-1:0] diode_cnt;
    logic [SAB_CW-1:0] prev_on;
    logic [SAB_CW-1:0] prev_off;
    logic [SAB_CW-1:0] clamp;
    logic [SAB_CW-1:0] blank_len;
    logic diode_seen;
    logic skip;
    logic gate;
    logic prop;
    logic arm;
  } sab_core_t;

  sab_core_t r;
  sab_core_t next_r;
  logic on_s;
  logic off_s;
  logic hi_s;
  logic uv_s;
  logic rst;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  sab_sync u_sync_on (
    .clk(clk),
    .srst(srst),
    .async_in(below_turn_on_threshold),
    .sync_out(on_s)
  );
  sab_sync u_sync_off (
    .clk(clk),
    .srst(srst),
    .async_in(above_turn_off_threshold),
    .sync_out(off_s)
  );
  sab_sync u_sync_hi (
    .clk(clk),
    .srst(srst),
    .async_in(drain_above_source),
    .sync_out(hi_s)
  );
  sab_sync u_sync_uv (
    .clk(clk),
    .srst(srst),
    .async_in(uv_flag),
    .sync_out(uv_s)
  );

  // Undervoltage comes from the analog side, so it is synchronised too;
  // the gate is forced off on the third clock edge after the flag rises.
  assign rst = srst | uv_s;

  // ----------------------------------------
  // Blanking length
  // ----------------------------------------
  function automatic logic [SAB_CW-1:0] sat_mul(input logic [SAB_CW-1:0] v,
                                                input int unsigned k10);
    logic [SAB_CW+5:0] p;
    p = (SAB_CW+6)'((int'(v) * int'(k10)) / 10);
    if (p > (SAB_CW+6)'(SAB_CNT_MAX)) begin
      sat_mul = SAB_CNT_MAX;
    end else begin
      sat_mul = p[SAB_CW-1:0];
    end
  endfunction

  function automatic logic [SAB_CW-1:0] calc_blank(input logic [SAB_CW-1:0] clamp,
                                                   input logic [SAB_CW-1:0] prev_off);
    logic [SAB_CW-1:0] b;
    logic [SAB_CW-1:0] o;
    o = sat_mul(prev_off, SAB_OFF_SCALE_X10);
    b = FLOOR;
    if (clamp > b) begin
      b = clamp;
    end
    if (o > b) begin
      b = o;
    end
    if (b > CEIL) begin
      b = CEIL;
    end
    calc_blank = b;
  endfunction

  function automatic logic [SAB_CW-1:0] inc(input logic [SAB_CW-1:0] v);
    inc = (v == SAB_CNT_MAX) ? v : v + 1'b1;
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.off_cnt = inc(r.off_cnt);
    unique case (r.st)
      SAB_OFF_WAIT: begin
        if (hi_s) begin
          next_r.st = SAB_BLANK;
          next_r.blank_cnt = '0;
          next_r.diode_cnt = '0;
          next_r.diode_seen = 1'b0;
          next_r.skip = 1'b0;
          next_r.blank_len = calc_blank(r.clamp, r.prev_off);
        end
      end
      SAB_BLANK: begin
        next_r.blank_cnt = inc(r.blank_cnt);
        // Diode conduction during blanking seen as turn-on comparator
        if (on_s) begin
          next_r.diode_seen = 1'b1;
          next_r.diode_cnt = inc(r.diode_cnt);
          if (r.diode_cnt >= MIN_ON) begin
            next_r.clamp = FLOOR;
          end
        end
        if (r.blank_cnt + 1'b1 >= r.blank_len) begin
          next_r.st = SAB_ARMED;
          next_r.arm = ~(r.diode_seen | on_s);
          next_r.skip = r.diode_seen | on_s;
        end
      end
      SAB_ARMED: begin
        // Skipped cycle waits for drain to rise again
        if (r.skip) begin
          if (hi_s && !on_s) begin
            next_r.st = SAB_OFF_WAIT;
            next_r.prev_off = r.off_cnt;
          end
        end else if (r.arm && on_s) begin
          next_r.st = SAB_ON;
          next_r.gate = 1'b1;
          next_r.arm = 1'b0;
          next_r.on_cnt = '0;
          next_r.prop = 1'b0;
        end
      end
      SAB_ON: begin
        next_r.on_cnt = inc(r.on_cnt);
        next_r.prop = ({1'b0, r.on_cnt} >= ({1'b0, r.prev_on} >> 1));
        // Turn-off comparator ignored until the minimum on-time passes
        if (off_s && r.on_cnt >= MIN_ON) begin
          next_r.st = SAB_OFF_WAIT;
          next_r.gate = 1'b0;
          next_r.prop = 1'b0;
          if (r.on_cnt > MIN_ON) begin
            next_r.prev_on = r.on_cnt;
            // Off time ends at this turn-on, not at this turn-off
            next_r.prev_off = r.off_cnt - r.on_cnt;
            next_r.off_cnt = '0;
          end else begin
            // False turn-on: time since the genuine turn-off is the ring
            next_r.clamp = sat_mul(r.off_cnt - r.on_cnt, SAB_RING_SCALE_X10);
          end
        end
      end
      default: begin
        next_r.st = SAB_OFF_WAIT;
        next_r.gate = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{st: SAB_OFF_WAIT, clamp: FLOOR, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign gate_drive_out = r.gate;
  assign prop_drive_enable = r.prop;
  assign armed = r.arm;
endmodule
`default_nettype wire
